// >>> hdl/gpl_port.sv
// 24-pin masked port with single-pin access and two-wire line forcing
`timescale 1ns/1ps
// Overview of operation
// - Clock drop holds clock line low until release
// - Data drop holds data line low until release
// - Port words 32 bits, groups A/B/C bytes
// - Top byte reserved, writes ignored
// - Direction bit one means output
// - Direction write changes masked pins only
// - Direction readback gives all 24 directions
// - Output write changes masked pins only
// - Port read gives present levels of pins
// - Index 0..23 selects A, B, C pins
// - Single direction set from flag, others kept
// - Direction query true when pin is output
// - Single write sets indexed value, drives if output
// - Single read returns indexed pin level
// - Index above 23 flags error, nothing changes
// - Released line undriven, rises unless target holds
// - Line state: released, low by self, low by target
module gpl_port
#(
    parameter int PINS = gpl_pkg::PIN_COUNT
)
(
    sys_clk,
    rst_b,
    cmd_valid,
    cmd_code,
    cmd_value,
    cmd_mask,
    pin_index,
    output_direction_flag,
    pin_value,
    scl_drop,
    scl_release,
    sda_drop,
    sda_release,
    gpio_in,
    gpio_out,
    gpio_oe_b,
    scl_in,
    scl_out,
    scl_oe_b,
    sda_in,
    sda_out,
    sda_oe_b,
    dir_word,
    level_word,
    pin_result,
    result_valid,
    bad_parameter_error,
    scl_state,
    sda_state
);
    input wire logic sys_clk;
    input wire logic rst_b;
    input wire logic cmd_valid;
    input wire gpl_pkg::gpl_cmd_type cmd_code;
    input wire logic [gpl_pkg::WORD_W-1:0] cmd_value;
    input wire logic [gpl_pkg::WORD_W-1:0] cmd_mask;
    input wire logic [gpl_pkg::INDEX_W-1:0] pin_index;
    input wire logic output_direction_flag;
    input wire logic pin_value;
    input wire logic scl_drop;
    input wire logic scl_release;
    input wire logic sda_drop;
    input wire logic sda_release;
    input wire logic [PINS-1:0] gpio_in;
    output logic [PINS-1:0] gpio_out;
    output logic [PINS-1:0] gpio_oe_b;
    input wire logic scl_in;
    output logic scl_out;
    output logic scl_oe_b;
    input wire logic sda_in;
    output logic sda_out;
    output logic sda_oe_b;
    output logic [gpl_pkg::WORD_W-1:0] dir_word;
    output logic [gpl_pkg::WORD_W-1:0] level_word;
    output logic pin_result;
    output logic result_valid;
    output logic bad_parameter_error;
    output gpl_pkg::gpl_line_type scl_state;
    output gpl_pkg::gpl_line_type sda_state;

    typedef struct packed
    {
        logic [PINS-1:0] dir;
        logic [PINS-1:0] val;
        logic [PINS-1:0] oe_b;
        logic scl_hold;
        logic sda_hold;
        logic scl_oe_b;
        logic sda_oe_b;
        logic [gpl_pkg::WORD_W-1:0] dir_word;
        logic [gpl_pkg::WORD_W-1:0] level_word;
        logic pin_result;
        logic result_valid;
        logic bad_param;
        gpl_pkg::gpl_line_type scl_state;
        gpl_pkg::gpl_line_type sda_state;
    } gpl_port_state_type;

    gpl_port_state_type state_r;
    gpl_port_state_type state_nxt;
    logic [PINS+1:0] sync_lvl;
    logic [PINS-1:0] pin_lvl;
    logic scl_lvl;
    logic sda_lvl;

    // Group mapping and reset words are fixed at three 8-pin groups
    if (PINS != gpl_pkg::PIN_COUNT)
    begin
        $error("PINS must equal the three 8-pin groups");
    end

    // Masked merge applied to the whole vector at once
    function automatic logic [PINS-1:0] merge_masked(
        input logic [PINS-1:0] old_v,
        input logic [gpl_pkg::WORD_W-1:0] new_v,
        input logic [gpl_pkg::WORD_W-1:0] mask
    );
        logic [PINS-1:0] m;
        m = mask[PINS-1:0];
        return (old_v & ~m) | (new_v[PINS-1:0] & m);
    endfunction

    // Classify a two-wire line from own hold and sampled level
    function automatic gpl_pkg::gpl_line_type line_class(
        input logic hold,
        input logic level
    );
        if (hold)
            return gpl_pkg::GPL_LINE_LOW_BY_SELF;
        else if (!level)
            return gpl_pkg::GPL_LINE_LOW_BY_TARGET;
        else
            return gpl_pkg::GPL_LINE_RELEASED_HIGH;
    endfunction

    function automatic logic [gpl_pkg::WORD_W-1:0] to_word(input logic [PINS-1:0] v);
        return {{(gpl_pkg::WORD_W - PINS){1'b0}}, v};
    endfunction

    // Single-pin answer: direction when asked for it, else level
    function automatic logic pin_reply(
        input logic want_dir,
        input logic dir_bit,
        input logic lvl_bit
    );
        if (want_dir)
            return dir_bit;
        else
            return lvl_bit;
    endfunction

    gpl_sync
    #(
        .WIDTH(PINS + 2)
    )
    u_sync
    (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in({sda_in, scl_in, gpio_in}),
        .sync_out(sync_lvl)
    );

    assign pin_lvl = sync_lvl[PINS-1:0];
    assign scl_lvl = sync_lvl[PINS];
    assign sda_lvl = sync_lvl[PINS+1];

    always_comb
    begin
        logic idx_ok;
        logic [4:0] idx;
        idx_ok = pin_index < gpl_pkg::INDEX_W'(PINS);
        idx = pin_index[4:0];
        state_nxt = state_r;
        state_nxt.result_valid = 1'b0;
        if (cmd_valid)
        begin
            unique case (cmd_code)
                gpl_pkg::GPL_CMD_PORT_DIR:
                begin
                    state_nxt.dir = merge_masked(state_r.dir, cmd_value, cmd_mask);
                end
                gpl_pkg::GPL_CMD_PORT_OUT:
                begin
                    state_nxt.val = merge_masked(state_r.val, cmd_value, cmd_mask);
                end
                gpl_pkg::GPL_CMD_PIN_DIR:
                begin
                    state_nxt.result_valid = 1'b1;
                    state_nxt.bad_param = !idx_ok;
                    state_nxt.pin_result = 1'b0;
                    if (idx_ok)
                    begin
                        state_nxt.dir[idx] = output_direction_flag;
                        state_nxt.pin_result = pin_reply(output_direction_flag,
                            state_r.dir[idx], pin_lvl[idx]);
                    end
                end
                gpl_pkg::GPL_CMD_PIN_OUT:
                begin
                    state_nxt.result_valid = 1'b1;
                    state_nxt.bad_param = !idx_ok;
                    state_nxt.pin_result = 1'b0;
                    if (idx_ok)
                    begin
                        state_nxt.val[idx] = pin_value;
                        state_nxt.pin_result = pin_reply(output_direction_flag,
                            state_r.dir[idx], pin_lvl[idx]);
                    end
                end
                gpl_pkg::GPL_CMD_PIN_QUERY:
                begin
                    state_nxt.result_valid = 1'b1;
                    state_nxt.bad_param = !idx_ok;
                    state_nxt.pin_result = 1'b0;
                    if (idx_ok)
                    begin
                        state_nxt.pin_result = pin_reply(output_direction_flag,
                            state_r.dir[idx], pin_lvl[idx]);
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (scl_release)
            state_nxt.scl_hold = 1'b0;
        if (scl_drop)
            state_nxt.scl_hold = 1'b1;
        if (sda_release)
            state_nxt.sda_hold = 1'b0;
        if (sda_drop)
            state_nxt.sda_hold = 1'b1;
        state_nxt.oe_b = ~state_nxt.dir;
        state_nxt.scl_oe_b = ~state_nxt.scl_hold;
        state_nxt.sda_oe_b = ~state_nxt.sda_hold;
        state_nxt.dir_word = to_word(state_nxt.dir);
        state_nxt.level_word = to_word(pin_lvl);
        state_nxt.scl_state = line_class(state_r.scl_hold, scl_lvl);
        state_nxt.sda_state = line_class(state_r.sda_hold, sda_lvl);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= '0;
            state_r.dir <= gpl_pkg::DIR_RESET;
            state_r.val <= gpl_pkg::OUT_RESET;
            state_r.oe_b <= ~gpl_pkg::DIR_RESET;
            state_r.scl_oe_b <= 1'b1;
            state_r.sda_oe_b <= 1'b1;
        end
        else
            state_r <= state_nxt;
    end

    assign gpio_out = state_r.val;
    assign gpio_oe_b = state_r.oe_b;
    assign scl_out = 1'b0;
    assign scl_oe_b = state_r.scl_oe_b;
    assign sda_out = 1'b0;
    assign sda_oe_b = state_r.sda_oe_b;
    assign dir_word = state_r.dir_word;
    assign level_word = state_r.level_word;
    assign pin_result = state_r.pin_result;
    assign result_valid = state_r.result_valid;
    assign bad_parameter_error = state_r.bad_param;
    assign scl_state = state_r.scl_state;
    assign sda_state = state_r.sda_state;
endmodule

// >>> shared/gpl_pkg.sv
// Shared constants and types for the 24-pin port with two-wire line drive
package gpl_pkg;
    localparam int PIN_COUNT = 24;
    localparam int WORD_W = 32;
    localparam int INDEX_W = 8;
    localparam int GROUP_W = 8;
    localparam int GROUP_A_LSB = 0;
    localparam int GROUP_B_LSB = 8;
    localparam int GROUP_C_LSB = 16;
    localparam int RESERVED_LSB = 24;
    localparam logic [23:0] DIR_RESET = 24'h00_0000;
    localparam logic [23:0] OUT_RESET = 24'h00_0000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0]
    {
        GPL_CMD_NONE = 3'h0,
        GPL_CMD_PORT_DIR = 3'h1,
        GPL_CMD_PORT_OUT = 3'h2,
        GPL_CMD_PIN_DIR = 3'h3,
        GPL_CMD_PIN_OUT = 3'h4,
        GPL_CMD_PIN_QUERY = 3'h5
    } gpl_cmd_type;

    typedef enum logic [1:0]
    {
        GPL_LINE_RELEASED_HIGH = 2'h0,
        GPL_LINE_LOW_BY_SELF = 2'h1,
        GPL_LINE_LOW_BY_TARGET = 2'h2
    } gpl_line_type;
endpackage

// >>> hdl/gpl_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module gpl_sync
#(
    parameter int WIDTH = 26
)
(
    sys_clk,
    rst_b,
    async_in,
    sync_out
);
    input wire logic sys_clk;
    input wire logic rst_b;
    input wire logic [WIDTH-1:0] async_in;
    output logic [WIDTH-1:0] sync_out;

    typedef struct packed
    {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gpl_sync_state_type;

    gpl_sync_state_type state_r;
    gpl_sync_state_type state_nxt;

    if (WIDTH < 1)
    begin
        $error("WIDTH must be positive");
    end

    always_comb
    begin
        state_nxt.stage1 = async_in;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign sync_out = state_r.stage2;
endmodule

// >>> sim/gpl_far_model.sv
// Far-side model: pin circuitry and pulled-up two-wire lines
`timescale 1ns/1ps
module gpl_far_model
(
    input wire logic [23:0] gpio_out,
    input wire logic [23:0] gpio_oe_b,
    input wire logic [23:0] ext_val,
    input wire logic scl_oe_b,
    input wire logic sda_oe_b,
    input wire logic tgt_scl_low,
    input wire logic tgt_sda_low,
    output logic [23:0] gpio_in,
    output logic scl_in,
    output logic sda_in
);
    assign gpio_in = (gpio_out & ~gpio_oe_b) | (ext_val & gpio_oe_b);
    // Pull-up; either party may hold low
    assign scl_in = scl_oe_b && !tgt_scl_low;
    assign sda_in = sda_oe_b && !tgt_sda_low;
endmodule

// >>> sim/gpl_port_sva.sv
// Checker for port, pin and line forcing
`timescale 1ns/1ps
module gpl_port_sva
#(
    parameter int PINS = 24
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire gpl_pkg::gpl_cmd_type cmd_code,
    input wire logic [7:0] pin_index,
    input wire logic scl_drop,
    input wire logic scl_release,
    input wire logic scl_oe_b,
    input wire logic sda_drop,
    input wire logic sda_oe_b,
    input wire logic [PINS-1:0] gpio_oe_b,
    input wire logic [31:0] dir_word,
    input wire logic [31:0] level_word,
    input wire logic result_valid,
    input wire logic bad_parameter_error,
    input wire gpl_pkg::gpl_line_type scl_state
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire pin_cmd = cmd_valid && cmd_code >= 3'h3;
    scl_hold_a: assert property ((scl_drop || !scl_oe_b && !scl_release) |=> !scl_oe_b)
        else $error("scl not held");
    sda_drop_a: assert property (sda_drop |=> !sda_oe_b)
        else $error("sda not pulled");
    scl_free_a: assert property (scl_release && !scl_drop |=> scl_oe_b)
        else $error("scl not freed");
    self_low_a: assert property (!scl_oe_b ##1 !scl_oe_b |-> scl_state == 2'h1)
        else $error("scl state wrong");
    top_zero_a: assert property (dir_word[31:24] == 8'h00 && level_word[31:24] == 8'h00)
        else $error("top byte set");
    oe_dir_a: assert property (gpio_oe_b == ~dir_word[PINS-1:0])
        else $error("oe mismatch");
    bad_idx_a: assert property (pin_cmd && pin_index > 8'h17 |=>
        result_valid && bad_parameter_error && $stable(dir_word)) else $error("bad index");
    good_idx_a: assert property (pin_cmd && pin_index < 8'h18 |=>
        result_valid && !bad_parameter_error) else $error("good index");
    dir_keep_a: assert property (!cmd_valid |=> $stable(dir_word))
        else $error("dir moved");
    cover property (pin_cmd && pin_index > 8'h17);
    cover property (scl_state == 2'h2);
    cover property (cmd_valid && cmd_code == 3'h1);
endmodule
bind gpl_port gpl_port_sva #(.PINS(PINS)) chk_u (.*);

// >>> sim/testbench.sv
// Self-checking bench for the 24-pin port
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rst_b, cmd_valid, output_direction_flag, pin_value;
    logic scl_drop, scl_release, sda_drop, sda_release, tgt_scl_low, tgt_sda_low;
    logic scl_in, scl_out, scl_oe_b, sda_in, sda_out, sda_oe_b;
    logic pin_result, result_valid, bad_parameter_error, seen_valid;
    logic [7:0] pin_index;
    logic [23:0] gpio_in, gpio_out, gpio_oe_b, ext_val;
    logic [31:0] cmd_value, cmd_mask, dir_word, level_word, exp_d, exp_o;
    gpl_pkg::gpl_cmd_type cmd_code;
    gpl_pkg::gpl_line_type scl_state, sda_state;
    int n_fail = 0;
    int n_tests = 0;
    gpl_port dut_u (.*);
    gpl_far_model far_u (.*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [2:0] c, input logic [31:0] v, m, input logic [7:0] i,
        input logic f);
        cmd_code = gpl_pkg::gpl_cmd_type'(c);
        cmd_value = v;
        cmd_mask = m;
        pin_index = i;
        output_direction_flag = f;
        pin_value = v[0];
        cmd_valid = 1'h1;
        @(posedge sys_clk);
        #1 cmd_valid = 1'h0;
        seen_valid = result_valid;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(posedge sys_clk);
        #1 s = 1'h0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic t_port;
        cmd(1, 32'hff5a_c3f0, 32'hff00_ffff, '0, '0);
        chk("dir", 32'h0000_c3f0, dir_word);
        chk("valid", '0, seen_valid);
        cmd(1, 32'hffff_ffff, 32'h00ff_0000, '0, '0);
        chk("dir", 32'h00ff_c3f0, dir_word);
        chk("oe", 32'h0000_3c0f, gpio_oe_b);
        cmd(2, 32'hffa5_a5a5, 32'hff0f_00ff, '0, '0);
        chk("out", 32'h0005_00a5, gpio_out);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("level", 32'h0005_3cac, level_word);
        $display("t_port done");
    endtask
    task automatic t_pin;
        int ix[3] = '{2, 15, 23};
        exp_d = 32'h00ff_c3f0;
        exp_o = 32'h0005_00a5;
        foreach (ix[k])
        begin
            cmd(3, '0, '0, 8'(ix[k]), 1'h1);
            exp_d[ix[k]] = 1'h1;
            chk("dir", exp_d, dir_word);
            cmd(5, '0, '0, 8'(ix[k]), 1'h1);
            chk("valid", 1'h1, seen_valid);
            chk("query", 1'h1, pin_result);
            cmd(4, 1'h1, '0, 8'(ix[k]), '0);
            exp_o[ix[k]] = 1'h1;
            chk("out", exp_o, gpio_out);
            repeat (3) @(posedge sys_clk);
            #1;
            cmd(5, '0, '0, 8'(ix[k]), '0);
            chk("drive", 1'h1, pin_result);
            cmd(3, '0, '0, 8'(ix[k]), '0);
            exp_d[ix[k]] = 1'h0;
            chk("oe", ~exp_d & 32'h00ff_ffff, gpio_oe_b);
            repeat (3) @(posedge sys_clk);
            #1;
            cmd(5, '0, '0, 8'(ix[k]), '0);
            chk("level", ext_val[ix[k]], pin_result);
        end
        cmd(3, '0, '0, 8'h18, 1'h1);
        chk("valid", 1'h1, seen_valid);
        chk("err", 1'h1, bad_parameter_error);
        chk("dir", exp_d, dir_word);
        cmd(3, '0, '0, 8'h20, 1'h1);
        chk("err", 1'h1, bad_parameter_error);
        chk("dir", exp_d, dir_word);
        cmd(5, '0, '0, 8'h02, 1'h1);
        chk("err", '0, bad_parameter_error);
        chk("query", '0, pin_result);
        $display("t_pin done");
    endtask
    task automatic t_line;
        pulse(scl_drop);
        chk("scl_oe", '0, scl_oe_b);
        chk("scl", 1'h1, scl_state);
        chk("scl_out", '0, scl_out);
        tgt_scl_low = 1'h1;
        pulse(scl_release);
        chk("scl_oe", 1'h1, scl_oe_b);
        chk("scl", 2'h2, scl_state);
        tgt_scl_low = 1'h0;
        pulse(sda_drop);
        chk("scl", '0, scl_state);
        chk("sda", '0, sda_in);
        chk("sda", 1'h1, sda_state);
        chk("sda_out", '0, sda_out);
        pulse(sda_release);
        chk("sda", 1'h1, sda_in);
        chk("sda", '0, sda_state);
        tgt_sda_low = 1'h1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("sda", 2'h2, sda_state);
        tgt_sda_low = 1'h0;
        $display("t_line done");
    endtask
    task automatic t_reset;
        chk("dir", '0, dir_word);
        chk("oe", 32'h00ff_ffff, gpio_oe_b);
        chk("scl_oe", 1'h1, scl_oe_b);
        chk("sda_oe", 1'h1, sda_oe_b);
        chk("out", '0, gpio_out);
        $display("t_reset done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        #50000;
        n_fail++;
        close_out();
    end
    initial
    begin
        {rst_b, cmd_valid, output_direction_flag, pin_value} = '0;
        {scl_drop, scl_release, sda_drop, sda_release, tgt_scl_low, tgt_sda_low} = '0;
        {cmd_value, cmd_mask, pin_index} = '0;
        cmd_code = gpl_pkg::GPL_CMD_NONE;
        ext_val = 24'h3c_3c3c;
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1'h1;
        t_reset();
        t_port();
        t_pin();
        t_line();
        rst_b = 1'h0;
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'h1;
        t_reset();
        close_out();
    end
endmodule
